//--- design/dsc_top.sv
`timescale 1ns/1ps
`include "dsc_defs.svh"

// Contract
// - Hold 16-bit step, add or subtract it.
// - Each step-up rising edge adds once; code cancels it with a same-cycle step-down, and a load wins.
// - Each step-down rising edge subtracts once; code cancels it with a same-cycle step-up, and a load wins.
// - Stepping gated by enable; source bit picks trigger.
// - Register bits make request edges in software mode.
// - Two prescalers divide by 4, 5, 6 independently.
// - Prescaler B bits 6:5, A bits 4:3.
// - Four channels, each own divider, glitchless switching.
// - Channel ratio from bits 13:0.
// - Divider fed by prescaler A, B or reference.
// - Divider source from bits 15:14.
// - Divider bypass passes reference path (reference or phase-detector clock) undivided.
// - Channel zero carries reference or phase-detector clock.
// - Enable bit gates reference onto channel zero.
// - Select bit picks phase-detector or input reference.
// - Four enables route reference to channels one-four.
// - Single-ended pin polarities invert independently.
// - Numerator is 24 bits wide.
module dsc_top
  import dsc_pkg::*;
#(
  parameter int NUM_W = 24,
  parameter int CHANNELS = 4
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register access
  input wire dsc_reg_req_s reg_req_i,
  output logic [15:0] reg_rdata_o,
  // Step pins from the external controller
  input wire dsc_step_s step_i,
  // Numerator base load and result
  input wire logic [NUM_W-1:0] numerator_base_i,
  input wire logic numerator_load_i,
  output logic [NUM_W-1:0] numerator_o,
  output logic numerator_update_o,
  // Reference and phase-detector clocks, sampled as levels
  input wire logic ref_clk_i,
  input wire logic pfd_clk_i,
  // Single-ended pin polarity, one bit per channel
  input wire logic [4:0] pol_p_i,
  input wire logic [4:0] pol_n_i,
  // Channel outputs, channel 0 first
  output logic [4:0] chan_p_o,
  output logic [4:0] chan_n_o
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Address decode, shared by write and read: {hit, slot}
  function automatic logic [3:0] dsc_decode(input logic [6:0] addr);
    logic [3:0] res;
    res = 4'h0;
    case (addr)
      `DSC_OFF_DCO_CONTROL: res = {1'b1, `DSC_IDX_DCO};
      `DSC_OFF_REF_ROUTING: res = {1'b1, `DSC_IDX_ROUTE};
      `DSC_OFF_STEP_SIZE: res = {1'b1, `DSC_IDX_STEP};
      `DSC_OFF_PRESCALER: res = {1'b1, `DSC_IDX_PRESC};
      `DSC_OFF_CHANNEL1_RATIO: res = {1'b1, `DSC_IDX_CH1};
      `DSC_OFF_CHANNEL2_RATIO: res = {1'b1, `DSC_IDX_CH2};
      `DSC_OFF_CHANNEL3_RATIO: res = {1'b1, `DSC_IDX_CH3};
      `DSC_OFF_CHANNEL4_RATIO: res = {1'b1, `DSC_IDX_CH4};
      default: res = 4'h0;
    endcase
    return res;
  endfunction

  // Prescaler code to ratio; reserved code gives zero (stopped)
  function automatic logic [2:0] dsc_ps_ratio(input logic [1:0] code);
    logic [2:0] r;
    r = 3'h0;
    case (code)
      `DSC_PS_CODE_DIV4: r = `DSC_PS_RATIO4;
      `DSC_PS_CODE_DIV5: r = `DSC_PS_RATIO5;
      `DSC_PS_CODE_DIV6: r = `DSC_PS_RATIO6;
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  dsc_state_s state_reg; // Every flop of the block
  dsc_state_s state_next; // Next value of it

  logic [3:0] wr_dec; // Write decode
  logic [3:0] rd_dec; // Read decode
  logic [15:0] dco_ctl; // Oscillator stepping control
  logic [15:0] route; // Reference routing
  logic [15:0] presc; // Prescaler ratios
  logic [1:0] pin_rise; // Synchronised pin edges {down, up}
  logic [1:0] sw_rise; // Register bit edges {down, up}
  logic [1:0] fire; // Accepted step requests {down, up}
  logic [NUM_W-1:0] step_ext; // Step value widened to numerator
  logic [2:0] psa_ratio; // Prescaler A ratio
  logic [2:0] psb_ratio; // Prescaler B ratio
  logic tick_a; // Prescaler A output pulse
  logic tick_b; // Prescaler B output pulse
  logic ref_tick; // Reference rising edge
  logic ref_path; // Reference or phase-detector level
  logic [3:0] ch_wrap; // Channel divider period end
  logic [3:0] ch_lvl; // Channel divided level

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.num_upd = 1'b0;
    ch_wrap = 4'h0;
    ch_lvl = 4'h0;

    // Register writes; unmapped addresses are ignored
    wr_dec = dsc_decode(reg_req_i.addr);
    rd_dec = dsc_decode(reg_req_i.addr);
    if (reg_req_i.wr && wr_dec[3])
    begin
      state_next.regs[wr_dec[2:0]] = reg_req_i.wdata;
    end
    // Read data held until the next read; unmapped reads zero
    if (reg_req_i.rd)
    begin
      state_next.rdata = rd_dec[3] ? state_reg.regs[rd_dec[2:0]] : `DSC_REG_RESET;
    end

    dco_ctl = state_reg.regs[`DSC_IDX_DCO];
    route = state_reg.regs[`DSC_IDX_ROUTE];
    presc = state_reg.regs[`DSC_IDX_PRESC];

    // Two-flop synchroniser, edge taken past the second flop
    state_next.pin_s1 = {step_i.step_down_request, step_i.step_up_request};
    state_next.pin_s2 = state_reg.pin_s1;
    state_next.pin_prev = state_reg.pin_s2;
    pin_rise = state_reg.pin_s2 & ~state_reg.pin_prev;

    // Software request bits make their own edges
    state_next.sw_prev = {dco_ctl[`DSC_BIT_SW_DOWN], dco_ctl[`DSC_BIT_SW_UP]};
    sw_rise = state_next.sw_prev & ~state_reg.sw_prev;

    // Enable gates stepping, source bit picks pins or register bits
    if (!dco_ctl[`DSC_BIT_STEP_EN])
    begin
      fire = 2'b00;
    end
    else if (dco_ctl[`DSC_BIT_STEP_SRC])
    begin
      fire = sw_rise;
    end
    else
    begin
      fire = pin_rise;
    end

    // Numerator update; both requests together cancel, load wins
    step_ext = {{(NUM_W-16){1'b0}}, state_reg.regs[`DSC_IDX_STEP]};
    if (numerator_load_i)
    begin
      state_next.num = numerator_base_i;
      state_next.num_upd = 1'b1;
    end
    else if (fire == 2'b01)
    begin
      state_next.num = NUM_W'(state_reg.num + step_ext);
      state_next.num_upd = 1'b1;
    end
    else if (fire == 2'b10)
    begin
      state_next.num = NUM_W'(state_reg.num - step_ext);
      state_next.num_upd = 1'b1;
    end

    // Prescalers: count clock cycles, pulse once per ratio
    psb_ratio = dsc_ps_ratio(presc[`DSC_PSB_LSB +: 2]);
    psa_ratio = dsc_ps_ratio(presc[`DSC_PSA_LSB +: 2]);
    tick_a = (psa_ratio != 3'h0) && (state_reg.psa_cnt >= 3'(psa_ratio - 3'h1));
    tick_b = (psb_ratio != 3'h0) && (state_reg.psb_cnt >= 3'(psb_ratio - 3'h1));
    state_next.psa_cnt = tick_a ? 3'h0 : 3'(state_reg.psa_cnt + 3'h1);
    state_next.psb_cnt = tick_b ? 3'h0 : 3'(state_reg.psb_cnt + 3'h1);
    if (psa_ratio == 3'h0)
    begin
      state_next.psa_cnt = 3'h0;
    end
    if (psb_ratio == 3'h0)
    begin
      state_next.psb_cnt = 3'h0;
    end

    // Reference clock rising edge, and the reference path
    state_next.ref_prev = ref_clk_i;
    ref_tick = ref_clk_i & ~state_reg.ref_prev;
    ref_path = route[`DSC_BIT_REF_SEL] ? ref_clk_i : pfd_clk_i;

    // Channel zero: gated reference path only
    state_next.out_p[0] = (route[`DSC_BIT_CH0_EN] & ref_path) ^ pol_p_i[0];
    state_next.out_n[0] = ~(route[`DSC_BIT_CH0_EN] & ref_path) ^ pol_n_i[0];

    // Channels one to four
    for (int k = 0; k < CHANNELS; k++)
    begin : ch_loop
      logic [15:0] cfg;
      logic src_tick;
      logic [13:0] act;
      logic [13:0] half;
      logic clk_lvl;
      // Locals cleared first, so no path can leave one latched
      src_tick = 1'b0;
      clk_lvl = 1'b0;
      cfg = state_reg.regs[`DSC_IDX_CH1 + 3'(k)];
      act = (state_reg.ch_ratio[k] == 14'h0000) ? 14'h0001 : state_reg.ch_ratio[k];
      half = 14'((15'(act) + 15'h0001) >> 1);
      case (dsc_src_e'(cfg[`DSC_MUX_LSB +: 2]))
        DSC_SRC_PRESCALER_A: src_tick = tick_a;
        DSC_SRC_PRESCALER_B: src_tick = tick_b;
        DSC_SRC_REFERENCE: src_tick = ref_tick;
        default: src_tick = 1'b0;
      endcase
      // Ratio changes only at a period end, so no pulse is cut
      ch_wrap[k] = src_tick && (state_reg.ch_cnt[k] >= 14'(act - 14'h0001));
      if (ch_wrap[k])
      begin
        state_next.ch_cnt[k] = 14'h0000;
        state_next.ch_ratio[k] = cfg[`DSC_DIV_LSB +: 14];
      end
      else if (src_tick)
      begin
        state_next.ch_cnt[k] = 14'(state_reg.ch_cnt[k] + 14'h0001);
      end
      ch_lvl[k] = state_reg.ch_cnt[k] < half;
      // Bypass routes the reference path undivided
      clk_lvl = route[`DSC_BIT_REF_CH1 + k] ? ref_path : ch_lvl[k];
      state_next.out_p[k+1] = clk_lvl ^ pol_p_i[k+1];
      state_next.out_n[k+1] = ~clk_lvl ^ pol_n_i[k+1];
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------
  assign reg_rdata_o = state_reg.rdata;
  assign numerator_o = state_reg.num;
  assign numerator_update_o = state_reg.num_upd;
  assign chan_p_o = state_reg.out_p;
  assign chan_n_o = state_reg.out_n;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Reset mutes every check; properties sample settled flops, decoded signals and inputs

  AST_STEP_UP: assert property (
    (fire == 2'b01 && !numerator_load_i) |=>
      numerator_o == NUM_W'($past(state_reg.num) + $past(step_ext)))
    else $error("Step up did not add the step value");

  AST_STEP_DOWN: assert property (
    (fire == 2'b10 && !numerator_load_i) |=>
      numerator_o == NUM_W'($past(state_reg.num) - $past(step_ext)))
    else $error("Step down did not subtract the step value");

  AST_DISABLED_HOLD: assert property (
    (!dco_ctl[`DSC_BIT_STEP_EN] && !numerator_load_i) |=> $stable(numerator_o))
    else $error("Numerator moved while stepping disabled");

  AST_SW_MODE: assert property (
    (dco_ctl[`DSC_BIT_STEP_EN] && dco_ctl[`DSC_BIT_STEP_SRC] && sw_rise == 2'b00
      && !numerator_load_i) |=> !numerator_update_o)
    else $error("Update without software edge in register mode");

  AST_PIN_SYNC: assert property (
    $rose(step_i.step_up_request) |-> ##2 pin_rise[0] ##1 !pin_rise[0])
    else $error("Pin edge not seen once after two flops");

  AST_PIN_SYNC_DOWN: assert property (
    $rose(step_i.step_down_request) |-> ##2 pin_rise[1] ##1 !pin_rise[1])
    else $error("Down pin edge not seen once after two flops");

  // A ratio write changes the period at once, so checks need a steady setting
  AST_PSA_DIV4: assert property (
    (tick_a && presc[`DSC_PSA_LSB +: 2] == `DSC_PS_CODE_DIV4)
      ##1 (!tick_a && $stable(presc))[*3] ##1 $stable(presc) |-> tick_a)
    else $error("Prescaler A not dividing by four");

  AST_PSB_DIV6: assert property (
    (tick_b && presc[`DSC_PSB_LSB +: 2] == `DSC_PS_CODE_DIV6) ##1 $stable(presc) [*5]
      |-> !tick_b && !$past(tick_b, 1) && !$past(tick_b, 2) && !$past(tick_b, 3)
      && !$past(tick_b, 4))
    else $error("Prescaler B ticked early at ratio six");

  AST_BYPASS: assert property (
    (route[`DSC_BIT_REF_CH1] && !pol_p_i[1]) |=> chan_p_o[1] == $past(ref_path))
    else $error("Bypassed channel one not following reference");

  AST_CH0_GATE: assert property (
    !route[`DSC_BIT_CH0_EN] |=> chan_p_o[0] == $past(pol_p_i[0]))
    else $error("Channel zero active while its enable is clear");

  AST_CH0_ROUTE: assert property (
    (route[`DSC_BIT_CH0_EN] && !pol_p_i[0]) |=>
      chan_p_o[0] == $past(route[`DSC_BIT_REF_SEL] ? ref_clk_i : pfd_clk_i))
    else $error("Channel zero not following the selected reference path");

  AST_POLARITY: assert property (
    (pol_p_i == pol_n_i) |=> chan_n_o == ~chan_p_o)
    else $error("Pin pair not complementary at equal polarity");

  AST_RATIO_HOLD: assert property (
    !ch_wrap[0] |=> $stable(state_reg.ch_ratio[0]))
    else $error("Channel one ratio changed mid-period");

  COV_STEP_UP: cover property (fire == 2'b01 ##1 numerator_update_o);
  COV_STEP_DOWN: cover property (fire == 2'b10 ##1 numerator_update_o);
  COV_SW_STEP: cover property (dco_ctl[`DSC_BIT_STEP_SRC] && sw_rise[0]);
  COV_CH_WRAP: cover property (ch_wrap[0] ##[1:50] ch_wrap[0]);
  COV_REF_FED: cover property (ref_tick && ch_wrap[2]);

endmodule

//--- design/dsc_defs.svh
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH

// ----------------------------------------
// Register offsets (7-bit register address)
// ----------------------------------------
`define DSC_OFF_DCO_CONTROL 7'h03
`define DSC_OFF_REF_ROUTING 7'h19
`define DSC_OFF_STEP_SIZE 7'h2B
`define DSC_OFF_PRESCALER 7'h2F
`define DSC_OFF_CHANNEL1_RATIO 7'h38
`define DSC_OFF_CHANNEL2_RATIO 7'h3E
`define DSC_OFF_CHANNEL3_RATIO 7'h43
`define DSC_OFF_CHANNEL4_RATIO 7'h48

// ----------------------------------------
// Slots of the internal register array
// ----------------------------------------
`define DSC_IDX_DCO 3'h0
`define DSC_IDX_ROUTE 3'h1
`define DSC_IDX_STEP 3'h2
`define DSC_IDX_PRESC 3'h3
`define DSC_IDX_CH1 3'h4
`define DSC_IDX_CH2 3'h5
`define DSC_IDX_CH3 3'h6
`define DSC_IDX_CH4 3'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DSC_BIT_STEP_EN 3
`define DSC_BIT_STEP_SRC 4
`define DSC_BIT_SW_UP 5
`define DSC_BIT_SW_DOWN 6
`define DSC_BIT_REF_SEL 9
`define DSC_BIT_CH0_EN 10
`define DSC_BIT_REF_CH1 11
`define DSC_PSA_LSB 3
`define DSC_PSB_LSB 5
`define DSC_DIV_LSB 0
`define DSC_MUX_LSB 14

// ----------------------------------------
// Reset values and prescaler codes
// ----------------------------------------
`define DSC_REG_RESET 16'h0000
`define DSC_NUM_RESET 24'h000000
`define DSC_PS_CODE_DIV4 2'h0
`define DSC_PS_CODE_DIV5 2'h1
`define DSC_PS_CODE_DIV6 2'h2
`define DSC_PS_RATIO4 3'h4
`define DSC_PS_RATIO5 3'h5
`define DSC_PS_RATIO6 3'h6

`endif

//--- design/dsc_pkg.sv
package dsc_pkg;

  // ----------------------------------------
  // Channel divider source, in code order
  // ----------------------------------------
  typedef enum logic [1:0] {
    DSC_SRC_PRESCALER_A,
    DSC_SRC_PRESCALER_B,
    DSC_SRC_REFERENCE,
    DSC_SRC_RESERVED
  } dsc_src_e;

  // Step request pins from the external controller
  typedef struct packed {
    logic step_down_request;
    logic step_up_request;
  } dsc_step_s;

  // Register access port
  typedef struct packed {
    logic [6:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } dsc_reg_req_s;

  // Whole state of the block
  typedef struct packed {
    logic [7:0][15:0] regs;
    logic [23:0] num;
    logic num_upd;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] pin_prev;
    logic [1:0] sw_prev;
    logic ref_prev;
    logic [2:0] psa_cnt;
    logic [2:0] psb_cnt;
    logic [3:0][13:0] ch_cnt;
    logic [3:0][13:0] ch_ratio;
    logic [4:0] out_p;
    logic [4:0] out_n;
    logic [15:0] rdata;
  } dsc_state_s;

endpackage

//--- tb/dsc_step_driver.sv
`timescale 1ns/1ps
// ----------------------------------------
// External controller driving the step pins
// ----------------------------------------
module dsc_step_driver
  import dsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // One-cycle step requests from the bench
  input wire logic up_go_i,
  input wire logic down_go_i,
  // Step pins towards the block
  output dsc_step_s step_o
);
  // Second cycle of each high pulse, down in bit 1
  logic [1:0] hold_reg;

  // A pin stays high two cycles, then low, so each step is one clean edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_reg <= 2'h0;
      step_o <= '0;
    end
    else
    begin
      hold_reg <= {down_go_i, up_go_i};
      step_o.step_up_request <= up_go_i | hold_reg[0];
      step_o.step_down_request <= down_go_i | hold_reg[1];
    end
  end
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
`include "dsc_defs.svh"
module testbench;
  import dsc_pkg::*;
  // ----------------------------------------
  // Bench signals
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  dsc_reg_req_s req = '0;
  logic [15:0] rdata;
  dsc_step_s step;
  logic [23:0] base = 24'h000000;
  logic [23:0] num;
  logic load = 1'b0;
  logic upd;
  logic ref_clk = 1'b0;
  logic pfd_clk = 1'b0;
  logic [4:0] pol_p = 5'h00;
  logic [4:0] pol_n = 5'h00;
  logic [4:0] ch_p;
  logic [4:0] ch_n;
  logic up_go = 1'b0;
  logic down_go = 1'b0;
  logic [15:0] rd;
  logic [4:0] prev;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int upd_cnt = 0;
  int edges [5];
  // Offsets: control, routing, step, prescaler, channels 1 to 4
  logic [6:0] offs [8] = '{`DSC_OFF_DCO_CONTROL, `DSC_OFF_REF_ROUTING, `DSC_OFF_STEP_SIZE,
    `DSC_OFF_PRESCALER, `DSC_OFF_CHANNEL1_RATIO, `DSC_OFF_CHANNEL2_RATIO, `DSC_OFF_CHANNEL3_RATIO, `DSC_OFF_CHANNEL4_RATIO};

  // ----------------------------------------
  // Design, partner and clock
  // ----------------------------------------
  dsc_top dsc_top_i (.clk_i(clk_i), .rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .step_i(step), .numerator_base_i(base), .numerator_load_i(load), .numerator_o(num),
    .numerator_update_o(upd), .ref_clk_i(ref_clk), .pfd_clk_i(pfd_clk), .pol_p_i(pol_p),
    .pol_n_i(pol_n), .chan_p_o(ch_p), .chan_n_o(ch_n));
  dsc_step_driver dsc_step_driver_i (.clk_i(clk_i), .rst_i(rst_i), .up_go_i(up_go),
    .down_go_i(down_go), .step_o(step));

  // 100 MHz clock
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  // Update pulses counted, so a doubled or missing pulse shows
  always @(posedge clk_i)
  begin
    cycles++;
    if (upd === 1'b1)
      upd_cnt++;
    if (cycles == 8000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Case compare, so unknown never matches
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  // One write strobe of one cycle
  task automatic reg_wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_i) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i) req <= '0;
  endtask

  // Read data is registered one cycle after the strobe edge
  task automatic reg_rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk_i) req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i) req <= '0;
    #1 d = rdata;
  endtask

  // Ask the controller for pin edges, then let the sync chain settle
  task automatic pin(input logic u, input logic d);
    @(posedge clk_i)
    begin
      up_go <= u;
      down_go <= d;
    end
    @(posedge clk_i)
    begin
      up_go <= 1'b0;
      down_go <= 1'b0;
    end
    tick(6);
  endtask

  // Rising edges of channels 1 to 4 over n cycles
  task automatic count(input int n);
    edges = '{0, 0, 0, 0, 0};
    prev = ch_p;
    repeat (n)
    begin
      tick(1);
      for (int c = 1; c < 5; c++)
        if (ch_p[c] === 1'b1 && prev[c] === 1'b0)
          edges[c]++;
      prev = ch_p;
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, readback, and an unmapped place
    foreach (offs[i])
    begin
      reg_rd(offs[i], rd);
      chk(rd, 24'h0);
    end
    foreach (offs[i]) reg_wr(offs[i], 16'hA5C3 ^ 16'(i));
    reg_wr(7'h10, 16'hFFFF);
    foreach (offs[i])
    begin
      reg_rd(offs[i], rd);
      chk(rd, 24'(16'hA5C3 ^ 16'(i)));
    end
    reg_rd(7'h10, rd);
    chk(rd, 24'h0);
    foreach (offs[i]) reg_wr(offs[i], 16'h0000);
    $display("register test done");
    // Software steps: enable plus register source, then request bits
    reg_wr(offs[2], 16'h0005);
    reg_wr(offs[0], 16'h0018);
    reg_wr(offs[0], 16'h0038);
    tick(3);
    chk(num, 24'h5);
    reg_wr(offs[0], 16'h0018);
    reg_wr(offs[0], 16'h0058);
    tick(3);
    chk(num, 24'h0);
    reg_wr(offs[0], 16'h0010);
    reg_wr(offs[0], 16'h0030);
    tick(3);
    chk(num, 24'h0);
    chk(24'(upd_cnt), 24'h2);
    $display("software step test done");
    // Pin steps across the 24-bit wrap
    reg_wr(offs[2], 16'hFFFE);
    reg_wr(offs[0], 16'h0008);
    base <= 24'hFFFFF0;
    load <= 1'b1;
    @(posedge clk_i) load <= 1'b0;
    tick(2);
    chk(num, 24'hFFFFF0);
    pin(1'b1, 1'b0);
    chk(num, 24'h00FFEE);
    pin(1'b0, 1'b1);
    chk(num, 24'hFFFFF0);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b0);
    chk(num, 24'h01FFEC);
    pin(1'b1, 1'b1);
    reg_wr(offs[0], 16'h0018);
    pin(1'b1, 1'b0);
    chk(num, 24'h01FFEC);
    chk(24'(upd_cnt), 24'h7);
    $display("pin step test done");
    // Dividers: A /4, B /6, then A /5; channels 1 and 4 fed by A, 2 and 3 by B
    reg_wr(offs[3], 16'h0040);
    reg_wr(offs[4], 16'h0002);
    reg_wr(offs[5], 16'h4003);
    reg_wr(offs[6], 16'h4005);
    reg_wr(offs[7], 16'h0009);
    tick(80);
    count(360);
    chk(24'(edges[1]), 24'h2D);
    chk(24'(edges[2]), 24'h14);
    chk(24'(edges[3]), 24'h0C);
    chk(24'(edges[4]), 24'h0A);
    reg_wr(offs[3], 16'h0048);
    tick(80);
    count(360);
    chk(24'(edges[1]), 24'h24);
    chk(24'(edges[2]), 24'h14);
    chk(24'(edges[4]), 24'h08);
    $display("divider test done");
    // Reference routing, bypass and pin polarity
    @(posedge clk_i) ref_clk <= 1'b1;
    reg_wr(offs[1], 16'h0E00);
    tick(4);
    chk(24'(ch_p[1:0]), 24'h3);
    chk(24'(ch_n[1:0]), 24'h0);
    @(posedge clk_i)
    begin
      pol_p <= 5'h01;
      pol_n <= 5'h02;
    end
    tick(4);
    chk(24'(ch_p[1:0]), 24'h2);
    chk(24'(ch_n[1:0]), 24'h2);
    @(posedge clk_i)
    begin
      pol_p <= 5'h00;
      pol_n <= 5'h00;
    end
    reg_wr(offs[1], 16'h0400);
    tick(4);
    chk(24'(ch_p[0]), 24'h0);
    @(posedge clk_i) pfd_clk <= 1'b1;
    tick(4);
    chk(24'(ch_p[0]), 24'h1);
    reg_wr(offs[1], 16'h0000);
    tick(4);
    chk(24'(ch_p[0]), 24'h0);
    $display("routing test done");
    // Stopped prescalers, a reference-fed channel and the unused source code
    reg_wr(offs[3], 16'h0078);
    reg_wr(offs[6], 16'h8003);
    reg_wr(offs[7], 16'hC002);
    fork
      repeat (440) @(posedge clk_i) ref_clk <= ~ref_clk;
      begin
        tick(80);
        count(360);
      end
    join
    chk(24'(edges[1]), 24'h00);
    chk(24'(edges[2]), 24'h00);
    chk(24'(edges[3]), 24'h3C);
    chk(24'(edges[4]), 24'h00);
    reg_wr(offs[6], 16'h0000);
    $display("source test done");
    end_of_test();
  end
endmodule
